// file: shared/power_good_supervisor_regs.vh
// Constants of the power-good supervisor: timing, offsets, fields, reset values
`ifndef POWER_GOOD_SUPERVISOR_REGS_VH
`define POWER_GOOD_SUPERVISOR_REGS_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define PGS_CLK_HZ          20000000
`define PGS_CYC_PER_MS      (`PGS_CLK_HZ / 1000)
`define PGS_BUCK_DG_MS      2
`define PGS_LIN_DG_MS       1
`define PGS_MON_START_MS    5
`define PGS_PB_DG_MS        50
`define PGS_REQ_DG_MS       50
`define PGS_HRST_DG_MS      30
`define PGS_HOLD_S          8
`define PGS_DLY0_MS         20
`define PGS_DLY1_MS         100
`define PGS_DLY2_MS         200
`define PGS_DLY3_MS         400
`define PGS_BUCK_DG_CYC     (`PGS_BUCK_DG_MS * `PGS_CYC_PER_MS)
`define PGS_LIN_DG_CYC      (`PGS_LIN_DG_MS * `PGS_CYC_PER_MS)
`define PGS_MON_START_CYC   (`PGS_MON_START_MS * `PGS_CYC_PER_MS)
`define PGS_PB_DG_CYC       (`PGS_PB_DG_MS * `PGS_CYC_PER_MS)
`define PGS_REQ_DG_CYC      (`PGS_REQ_DG_MS * `PGS_CYC_PER_MS)
`define PGS_HRST_DG_CYC     (`PGS_HRST_DG_MS * `PGS_CYC_PER_MS)
`define PGS_HOLD_CYC        (`PGS_HOLD_S * 1000 * `PGS_CYC_PER_MS)
`define PGS_DLY0_CYC        (`PGS_DLY0_MS * `PGS_CYC_PER_MS)
`define PGS_DLY1_CYC        (`PGS_DLY1_MS * `PGS_CYC_PER_MS)
`define PGS_DLY2_CYC        (`PGS_DLY2_MS * `PGS_CYC_PER_MS)
`define PGS_DLY3_CYC        (`PGS_DLY3_MS * `PGS_CYC_PER_MS)

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PGS_ADDR_CTRL       8'h00
`define PGS_ADDR_STATUS     8'h04
`define PGS_ADDR_INT        8'h08
`define PGS_ADDR_MASK       8'h0C

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define PGS_CTRL_LIN_BIT    0
`define PGS_CTRL_DLY_LSB    1
`define PGS_CTRL_DLY_MSB    2
`define PGS_INT_RAIL_FAULT  0
`define PGS_INT_LONG_PRESS  1
`define PGS_INT_PB_CHANGE   2
`define PGS_INT_REQ_CHANGE  3
`define PGS_INT_HRST_ASSERT 4
`define PGS_INT_WIDTH       5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PGS_CTRL_RST        3'h0
`define PGS_INT_RST         5'h00
`define PGS_MASK_RST        5'h00
`define PGS_PIN_IDLE        3'h5

// ----------------------------------------------------------------------------
// Device states
// ----------------------------------------------------------------------------
`define PGS_ST_OFF          2'h0
`define PGS_ST_ACTIVE       2'h1
`define PGS_ST_SLEEP        2'h2
`define PGS_ST_RESET        2'h3

`endif

// file: verilog/power_good_supervisor.v
// Power-good supervisor: rail monitors, pin filters, long-press detect, registers
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "power_good_supervisor_regs.vh"

// ----------------------------------------------------------------------------
// Level filter: output follows input once stable for LIMIT cycles
// ----------------------------------------------------------------------------
module pgs_level_filter #(
   parameter          LIMIT = 1000,
   parameter          W     = 28,
   parameter [0:0]    INIT  = 1'b0
) (
   input  wire        i_clk,
   input  wire        i_sys_rst,
   input  wire        i_level,
   output reg         o_level
);
   reg [W-1:0] cnt;                    // Stable-time counter

   // Count while input differs from accepted level
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt     <= {W{1'b0}};
         o_level <= INIT;
      end else if (i_level == o_level) begin
         cnt <= {W{1'b0}};
      end else if (cnt == LIMIT[W-1:0] - 1'b1) begin
         // Stable long enough: accept
         o_level <= i_level;
         cnt     <= {W{1'b0}};
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule // pgs_level_filter

// ----------------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------------
module power_good_supervisor #(
   parameter          W         = 28,
   parameter          BUCK_DG   = `PGS_BUCK_DG_CYC,
   parameter          LIN_DG    = `PGS_LIN_DG_CYC,
   parameter          MON_START = `PGS_MON_START_CYC,
   parameter          PB_DG     = `PGS_PB_DG_CYC,
   parameter          REQ_DG    = `PGS_REQ_DG_CYC,
   parameter          HRST_DG   = `PGS_HRST_DG_CYC,
   parameter          HOLD      = `PGS_HOLD_CYC,
   parameter          DLY0      = `PGS_DLY0_CYC,
   parameter          DLY1      = `PGS_DLY1_CYC,
   parameter          DLY2      = `PGS_DLY2_CYC,
   parameter          DLY3      = `PGS_DLY3_CYC
) (
   input  wire        i_clk,
   input  wire        i_sys_rst,
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   input  wire [6:0]  i_rail_enable,
   input  wire [6:0]  i_rail_in_regulation,
   input  wire [1:0]  i_device_state,
   input  wire        i_sequencer_done,
   input  wire        i_pushbutton_input_n,
   input  wire        i_power_request_pin,
   input  wire        i_hard_reset_pin_n,
   output reg         o_main_power_ok,
   output reg         o_aux_regulator_power_ok,
   output reg         o_power_down_request,
   output reg         o_long_press,
   output wire        o_pushbutton_pressed,
   output wire        o_power_request,
   output wire        o_hard_reset_asserted,
   output wire        o_irq
);
   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   localparam [6:0] BASE_COVER = 7'h1F;  // Bucks [2:0], load switches [4:3]
   localparam [6:0] LIN_COVER  = 7'h60;  // Linear rails [6:5]
   reg  [2:0]  ctrl;                   // Linear include, delay select
   reg  [4:0]  int_status;             // Sticky event bits
   reg  [4:0]  int_mask;               // Interrupt enables
   reg  [2:0]  sync1;                  // Pin synchroniser stage 1
   reg  [2:0]  sync2;                  // Pin synchroniser stage 2
   reg  [2:0]  sync3;                  // Pin synchroniser stage 3
   reg  [2:0]  pin_agreed;             // Level once stages 2 and 3 agree
   wire [2:0]  pin_filt;               // Deglitched pins
   reg  [2:0]  pin_prev;               // Previous deglitched pins
   wire [6:0]  raw_fault;              // Undeglitched rail faults
   wire [6:0]  rail_fault;             // Deglitched rail faults
   reg         any_fault_prev;         // Edge detect for fault
   reg         fault_seen;             // Fault latched until resequence
   reg  [W-1:0] hold_cnt;              // Long-press counter
   reg         hold_done;              // Long press already reported
   reg  [W-1:0] rel_cnt;               // Release delay counter
   reg         released;               // Release delay elapsed
   reg  [W-1:0] rel_limit;             // Selected release delay
   wire [6:0]  main_cover;             // Rails under the main output
   wire        any_fault;              // Any deglitched rail fault
   wire        fault_evt;              // New fault this cycle
   wire        long_evt;               // Long press reached this cycle
   wire [4:0]  evt;                    // Event vector
   wire [4:0]  w1c;                    // Bits cleared by this write
   wire        pressed;                // Pushbutton held low

   // -------------------------------------------------------------------------
   // Pin synchronisers and filters
   // -------------------------------------------------------------------------
   wire [2:0] pin_raw = {i_hard_reset_pin_n, i_power_request_pin, i_pushbutton_input_n};
   // Three-stage synchroniser, change taken once stages agree
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         sync1      <= `PGS_PIN_IDLE;
         sync2      <= `PGS_PIN_IDLE;
         sync3      <= `PGS_PIN_IDLE;
         pin_agreed <= `PGS_PIN_IDLE;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_agreed <= (sync2 & sync3) | (pin_agreed & (sync2 ^ sync3));
      end
   end

   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_pin
         pgs_level_filter #(
            .LIMIT (p == 2 ? HRST_DG : (p == 1 ? REQ_DG : PB_DG)),
            .W     (W),
            .INIT  (p != 1)
         ) u_filt (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_level   (pin_agreed[p]),
            .o_level   (pin_filt[p])
         );
      end
   endgenerate

   assign pressed               = ~pin_filt[0];
   assign o_pushbutton_pressed  = pressed;
   assign o_power_request       = pin_filt[1];
   assign o_hard_reset_asserted = ~pin_filt[2];

   // -------------------------------------------------------------------------
   // Long-press detect
   // -------------------------------------------------------------------------
   assign long_evt = pressed & ~hold_done & (hold_cnt == HOLD[W-1:0] - 1'b1);
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         hold_cnt     <= {W{1'b0}};
         hold_done    <= 1'b0;
         o_long_press <= 1'b0;
      end else begin
         o_long_press <= long_evt;
         if (!pressed) begin
            hold_cnt  <= {W{1'b0}};
            hold_done <= 1'b0;
         end else if (long_evt) begin
            hold_done <= 1'b1;
         end else if (!hold_done) begin
            hold_cnt <= hold_cnt + 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Rail monitors
   // -------------------------------------------------------------------------
   genvar r;
   generate
      for (r = 0; r < 7; r = r + 1) begin : g_rail
         reg [W-1:0] mon_cnt;          // Monitor start counter
         reg         mon_on;           // Rail being checked
         always @(posedge i_clk) begin
            if (i_sys_rst) begin
               mon_cnt <= {W{1'b0}};
               mon_on  <= 1'b0;
            end else if (!i_rail_enable[r]) begin
               mon_cnt <= {W{1'b0}};
               mon_on  <= 1'b0;
            end else if (mon_cnt == MON_START[W-1:0] - 1'b1) begin
               mon_on <= 1'b1;
            end else begin
               mon_cnt <= mon_cnt + 1'b1;
            end
         end

         assign raw_fault[r] = i_rail_enable[r] & mon_on & ~i_rail_in_regulation[r];
         pgs_level_filter #(
            .LIMIT (r < 3 ? BUCK_DG : LIN_DG),
            .W     (W),
            .INIT  (1'b0)
         ) u_dg (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .i_level   (raw_fault[r]),
            .o_level   (rail_fault[r])
         );
      end
   endgenerate

   assign any_fault = |rail_fault;
   assign fault_evt = any_fault & ~any_fault_prev;

   // Fault latch and power-down request
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         any_fault_prev       <= 1'b0;
         fault_seen           <= 1'b0;
         o_power_down_request <= 1'b0;
      end else begin
         any_fault_prev <= any_fault;
         o_power_down_request <= fault_evt;
         if (fault_evt) begin
            fault_seen <= 1'b1;
         end else if (!i_sequencer_done) begin
            // New sequence clears it
            fault_seen <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Release delay
   // -------------------------------------------------------------------------
   // delay selector
   always @* begin
      case (ctrl[`PGS_CTRL_DLY_MSB:`PGS_CTRL_DLY_LSB])
         2'h0:    rel_limit = DLY0[W-1:0];
         2'h1:    rel_limit = DLY1[W-1:0];
         2'h2:    rel_limit = DLY2[W-1:0];
         default: rel_limit = DLY3[W-1:0];
      endcase
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         rel_cnt  <= {W{1'b0}};
         released <= 1'b0;
      end else if (fault_seen || i_device_state == `PGS_ST_OFF ||
                   i_device_state == `PGS_ST_RESET) begin
         rel_cnt  <= {W{1'b0}};
         released <= 1'b0;
      end else if (!i_sequencer_done) begin
         rel_cnt <= {W{1'b0}};
      end else if (!released) begin
         if (rel_cnt >= rel_limit - 1'b1) begin
            released <= 1'b1;
         end else begin
            rel_cnt <= rel_cnt + 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Power-good outputs
   // -------------------------------------------------------------------------
   // base coverage
   assign main_cover = BASE_COVER | (ctrl[`PGS_CTRL_LIN_BIT] ? LIN_COVER : 7'h00);

   // Registered power-good levels
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_main_power_ok          <= 1'b0;
         o_aux_regulator_power_ok <= 1'b0;
      end else begin
         // low if all off or fault
         o_main_power_ok <= released && !fault_seen && !any_fault && (i_device_state == `PGS_ST_ACTIVE) &&
                            (|(i_rail_enable & main_cover)) && !(|(rail_fault & main_cover));
         o_aux_regulator_power_ok <= released && !fault_seen && !any_fault &&
                            (i_device_state == `PGS_ST_ACTIVE || i_device_state == `PGS_ST_SLEEP) &&
                            (|(i_rail_enable & LIN_COVER)) && !(|(rail_fault & LIN_COVER));
      end
   end

   // -------------------------------------------------------------------------
   // Events and interrupt
   // -------------------------------------------------------------------------
   assign evt[`PGS_INT_RAIL_FAULT]  = fault_evt;
   assign evt[`PGS_INT_LONG_PRESS]  = long_evt;
   assign evt[`PGS_INT_PB_CHANGE]   = pin_filt[0] ^ pin_prev[0];
   assign evt[`PGS_INT_REQ_CHANGE]  = pin_filt[1] ^ pin_prev[1];
   assign evt[`PGS_INT_HRST_ASSERT] = ~pin_filt[2] & pin_prev[2];
   assign w1c = (i_wr && i_addr == `PGS_ADDR_INT) ? i_wdata[4:0] : 5'h00;
   assign o_irq = |(int_status & int_mask);

   // Sticky status, set wins over clear
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         pin_prev   <= `PGS_PIN_IDLE;
         int_status <= `PGS_INT_RST;
      end else begin
         pin_prev   <= pin_filt;
         int_status <= (int_status & ~w1c) | evt;
      end
   end

   // -------------------------------------------------------------------------
   // Register bus
   // -------------------------------------------------------------------------
   // Register writes
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl     <= `PGS_CTRL_RST;
         int_mask <= `PGS_MASK_RST;
      end else if (i_wr) begin
         case (i_addr)
            `PGS_ADDR_CTRL: ctrl     <= i_wdata[2:0];
            `PGS_ADDR_MASK: int_mask <= i_wdata[4:0];
            default:        ;
         endcase
      end
   end

   // Read data one cycle after the strobe
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0;
      end else if (i_rd) begin
         case (i_addr)
            `PGS_ADDR_CTRL:   o_rdata <= {29'h0, ctrl};
            `PGS_ADDR_STATUS: o_rdata <= {16'h0, rail_fault, 2'h0, fault_seen, released, ~pin_filt[2], pin_filt[1],
                                          pressed, o_aux_regulator_power_ok, o_main_power_ok};
            `PGS_ADDR_INT:    o_rdata <= {27'h0, int_status};
            `PGS_ADDR_MASK:   o_rdata <= {27'h0, int_mask};
            default:          o_rdata <= 32'h0;
         endcase
      end else begin
         o_rdata <= 32'h0;
      end
   end
endmodule // power_good_supervisor

// file: bench/pgs_port_checker.sv
// Port-level assertions for the power-good supervisor
`timescale 1ns/10ps
`include "power_good_supervisor_regs.vh"
module pgs_port_checker #(
   parameter LIN_DG = 4,
   parameter PB_DG  = 20,
   parameter DLY0   = 30
) (
   input wire        i_clk,
   input wire        i_sys_rst,
   input wire        i_rd,
   input wire [31:0] o_rdata,
   input wire [6:0]  i_rail_enable,
   input wire [6:0]  i_rail_in_regulation,
   input wire [1:0]  i_device_state,
   input wire        i_sequencer_done,
   input wire        i_pushbutton_input_n,
   input wire        o_main_power_ok,
   input wire        o_aux_regulator_power_ok,
   input wire        o_power_down_request,
   input wire        o_long_press,
   input wire        o_pushbutton_pressed,
   input wire        o_irq
);
   // ---------------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------------
   int pb_low  = 0;  // Cycles with the button pin low
   int flt_cnt = 0;  // Cycles with an enabled rail out of regulation
   int seq_cnt = 0;  // Cycles with the sequence complete
   // Count run lengths; each drops to zero when its condition goes false
   always @(posedge i_clk) begin
      pb_low  <= i_pushbutton_input_n ? 0 : pb_low + 1;
      flt_cnt <= |(i_rail_enable & ~i_rail_in_regulation) ? flt_cnt + 1 : 0;
      seq_cnt <= i_sequencer_done ? seq_cnt + 1 : 0;
   end
   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_reset_quiet: assert property ($fell(i_sys_rst) |-> !(o_main_power_ok | o_irq | o_long_press) && o_rdata == 0)
      else $error("outputs not quiet after reset");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read slot");
   a_main_active: assert property (o_main_power_ok |-> $past(i_device_state) == `PGS_ST_ACTIVE)
      else $error("main ok outside active");
   a_aux_states: assert property (o_aux_regulator_power_ok |-> $past(i_device_state) inside {2'h1, 2'h2})
      else $error("aux ok outside active or sleep");
   a_down_pulse: assert property (o_power_down_request |=> !o_power_down_request)
      else $error("power down request too long");
   a_press_pulse: assert property (o_long_press |-> o_pushbutton_pressed ##1 !o_long_press)
      else $error("long press pulse wrong");
   a_fault_drops: assert property (o_power_down_request |=> !o_main_power_ok && !o_aux_regulator_power_ok)
      else $error("power ok kept after fault");
   a_pb_filter: assert property ($rose(o_pushbutton_pressed) |-> pb_low >= PB_DG)
      else $error("button accepted too early");
   a_fault_deglitch: assert property (o_power_down_request |-> $past(flt_cnt) >= LIN_DG)
      else $error("rail fault not deglitched");
   a_release_delay: assert property ($rose(o_main_power_ok) |-> seq_cnt >= DLY0)
      else $error("power ok released too early");
   c_release: cover property ($rose(o_main_power_ok));
   c_fault: cover property (o_power_down_request);
   c_long: cover property (o_long_press);
endmodule // pgs_port_checker

bind power_good_supervisor pgs_port_checker #(.LIN_DG(LIN_DG), .PB_DG(PB_DG), .DLY0(DLY0)) chk_u (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_rd(i_rd), .o_rdata(o_rdata), .i_rail_enable(i_rail_enable),
   .i_rail_in_regulation(i_rail_in_regulation), .i_device_state(i_device_state),
   .i_sequencer_done(i_sequencer_done), .i_pushbutton_input_n(i_pushbutton_input_n),
   .o_main_power_ok(o_main_power_ok), .o_aux_regulator_power_ok(o_aux_regulator_power_ok),
   .o_power_down_request(o_power_down_request), .o_long_press(o_long_press),
   .o_pushbutton_pressed(o_pushbutton_pressed), .o_irq(o_irq));

// file: bench/pgs_host_model.sv
// Processor-side driver of the power request and hard reset pins
`timescale 1ns/10ps
module pgs_host_model (
   input  wire i_clk,
   output reg  o_power_request_pin,
   output reg  o_hard_reset_pin_n
);
   // Idle: no request, hard reset released
   initial begin
      o_power_request_pin = 1'h0;
      o_hard_reset_pin_n  = 1'h1;
   end
   // Drive one pin; a positive hold returns it after that many cycles
   task put(input logic sel, input logic lvl, input int hold);
      @(posedge i_clk);
      if (sel) o_hard_reset_pin_n <= lvl;
      else o_power_request_pin <= lvl;
      if (hold > 0) begin
         repeat (hold) @(posedge i_clk);
         if (sel) o_hard_reset_pin_n <= !lvl;
         else o_power_request_pin <= !lvl;
      end
   endtask
endmodule // pgs_host_model

// file: bench/power_good_supervisor_test.sv
// Self-checking testbench for the power-good supervisor
`timescale 1ns/10ps
`include "power_good_supervisor_regs.vh"
module power_good_supervisor_test;
   localparam int BDG = 8;
   localparam int LDG = 4;
   localparam int MON = 6;
   localparam int PDG = 20;
   localparam int RDG = 20;
   localparam int HDG = 12;
   localparam int HLD = 60;
   int          dly_tab [4] = '{30, 40, 50, 60};  // Release delays per code
   logic        clk   = 1'h0;
   logic        rst   = 1'h1;
   logic [7:0]  addr  = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr_s  = 1'h0;
   logic        rd_s  = 1'h0;
   logic [6:0]  en    = 7'h00;                    // Rail enables
   logic [6:0]  ok    = 7'h00;                    // Rails in regulation
   logic [1:0]  st    = `PGS_ST_OFF;
   logic        seq   = 1'h0;
   logic        pb_n  = 1'h1;
   wire  [31:0] rdata;
   wire         req_pin, hrst_n, main_ok, aux_ok, pdr, lpress, pressed, preq, hrst_a, irq;
   int          errors = 0;
   int          total_checks = 0;
   int          n, m, i;
   always #25 clk = ~clk;
   power_good_supervisor #(.BUCK_DG(BDG), .LIN_DG(LDG), .MON_START(MON), .PB_DG(PDG), .REQ_DG(RDG),
      .HRST_DG(HDG), .HOLD(HLD), .DLY0(30), .DLY1(40), .DLY2(50), .DLY3(60)) dut_u (
      .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
      .o_rdata(rdata), .i_rail_enable(en), .i_rail_in_regulation(ok), .i_device_state(st),
      .i_sequencer_done(seq), .i_pushbutton_input_n(pb_n), .i_power_request_pin(req_pin),
      .i_hard_reset_pin_n(hrst_n), .o_main_power_ok(main_ok), .o_aux_regulator_power_ok(aux_ok),
      .o_power_down_request(pdr), .o_long_press(lpress), .o_pushbutton_pressed(pressed),
      .o_power_request(preq), .o_hard_reset_asserted(hrst_a), .o_irq(irq));
   pgs_host_model host_u (.i_clk(clk), .o_power_request_pin(req_pin), .o_hard_reset_pin_n(hrst_n));
   // ---------------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task span(input string what, input int seen, input int lo, input int hi);
      check(what, (seen >= lo && seen <= hi) ? 32'h1 : 32'h0, 32'h1);
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      @(posedge clk);
      wr_s <= 1'h0;
   endtask
   task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clk);
      rd_s <= 1'h0;
      #1;
      check(what, rdata, exp);
   endtask
   function automatic logic probe(input int sel);
      case (sel)
         0: return main_ok;
         1: return pdr;
         2: return pressed;
         3: return lpress;
         4: return preq;
         default: return hrst_a;
      endcase
   endfunction
   // Cycles until the chosen output goes high, capped at lim
   task wait_on(input int sel, input int lim, output int cnt);
      cnt = 0;
      while (probe(sel) !== 1'h1 && cnt < lim) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out;
   end
   // ---------------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      rd_chk("ctrl", `PGS_ADDR_CTRL, 32'h0);
      rd_chk("status", `PGS_ADDR_STATUS, 32'h0);
      rd_chk("int", `PGS_ADDR_INT, 32'h0);
      rd_chk("mask", `PGS_ADDR_MASK, 32'h0);
      wr(8'h10, 32'hFFFF);
      rd_chk("unmapped", 8'h10, 32'h0);
      $display("test reset done");
      en <= 7'h1F;
      ok <= 7'h7F;
      st <= `PGS_ST_ACTIVE;
      for (i = 0; i < 4; i++) begin
         wr(`PGS_ADDR_CTRL, i << `PGS_CTRL_DLY_LSB);
         seq <= 1'h1;
         wait_on(0, 200, n);
         span("release delay", n, dly_tab[i] + 1, dly_tab[i] + 3);
         check("aux no rail", aux_ok, 1'h0);
         if (i == 0) rd_chk("status up", `PGS_ADDR_STATUS, 32'h21);
         seq <= 1'h0;
         st <= `PGS_ST_OFF;
         tick(3);
         check("main off", main_ok, 1'h0);
         st <= `PGS_ST_ACTIVE;
      end
      $display("test delays done");
      en <= 7'h60;
      wr(`PGS_ADDR_CTRL, 32'h0);
      seq <= 1'h1;
      tick(40);
      check("main lin out", main_ok, 1'h0);
      check("aux lin", aux_ok, 1'h1);
      wr(`PGS_ADDR_CTRL, 32'h1);
      tick(3);
      check("main lin in", main_ok, 1'h1);
      st <= `PGS_ST_SLEEP;
      tick(3);
      check("main sleep", main_ok, 1'h0);
      check("aux sleep", aux_ok, 1'h1);
      st <= `PGS_ST_RESET;
      tick(3);
      check("aux reset", aux_ok, 1'h0);
      $display("test coverage done");
      st <= `PGS_ST_ACTIVE;
      seq <= 1'h0;
      en <= 7'h1F;
      wr(`PGS_ADDR_CTRL, 32'h0);
      seq <= 1'h1;
      wait_on(0, 100, n);
      en <= 7'h1E;
      ok <= 7'h7E;
      wait_on(1, 20, n);
      check("disabled rail", n, 20);
      check("main kept", main_ok, 1'h1);
      ok <= 7'h7C;
      tick(BDG - 3);
      ok <= 7'h7E;
      wait_on(1, 20, n);
      check("glitch ignored", n, 20);
      ok <= 7'h7C;
      wait_on(1, 40, n);
      span("buck deglitch", n, BDG, BDG + 3);
      tick(2);
      check("main after fault", main_ok, 1'h0);
      rd_chk("fault int", `PGS_ADDR_INT, 32'h1);
      check("irq masked", irq, 1'h0);
      wr(`PGS_ADDR_MASK, 32'h1);
      tick(1);
      check("irq on", irq, 1'h1);
      ok <= 7'h7E;
      seq <= 1'h0;
      wr(`PGS_ADDR_INT, 32'h1);
      tick(1);
      check("irq cleared", irq, 1'h0);
      en <= 7'h3E;
      ok <= 7'h5E;
      wait_on(1, 40, n);
      span("monitor start", n, MON + LDG, MON + LDG + 4);
      en <= 7'h1E;
      ok <= 7'h7F;
      wr(`PGS_ADDR_INT, 32'h1F);
      $display("test faults done");
      for (i = 0; i < 2; i++) begin
         pb_n <= 1'h0;
         tick(PDG - 4);
         pb_n <= 1'h1;
         tick(3);
      end
      check("pb bounce", pressed, 1'h0);
      pb_n <= 1'h0;
      wait_on(2, 60, n);
      span("pb filter", n, PDG + 2, PDG + 6);
      wait_on(3, HLD + 40, m);
      span("hold time", n + m, HLD, HLD + PDG + 8);
      rd_chk("pb int", `PGS_ADDR_INT, 32'h6);
      pb_n <= 1'h1;
      tick(PDG + 8);
      check("pb released", pressed, 1'h0);
      wr(`PGS_ADDR_INT, 32'h1F);
      host_u.put(1'h0, 1'h1, RDG - 5);
      tick(RDG + 8);
      check("req glitch", preq, 1'h0);
      host_u.put(1'h0, 1'h1, 0);
      wait_on(4, 60, n);
      span("req filter", n, RDG + 2, RDG + 7);
      host_u.put(1'h1, 1'h0, 0);
      wait_on(5, 60, n);
      span("hrst filter", n, HDG + 2, HDG + 7);
      tick(2);
      rd_chk("pin int", `PGS_ADDR_INT, 32'h18);
      wr(`PGS_ADDR_MASK, 32'h10);
      tick(1);
      check("hrst irq", irq, 1'h1);
      wr(`PGS_ADDR_INT, 32'h1F);
      tick(1);
      check("irq clear", irq, 1'h0);
      $display("test pins done");
      close_out;
   end
endmodule // power_good_supervisor_test
